// [psdm_mapper.sv]
// Program/data space address mapper top
`timescale 1ns/1ps
`default_nettype none
module psdm_mapper
(
   // Clock and reset
   input wire logic clock,
   input wire logic resetn,
   // Control values
   input wire logic [7:0] table_page_register,
   input wire logic [7:0] visibility_page_register,
   input wire logic program_space_visibility_enable,
   // Instruction fetch
   input wire logic fetch_advance,
   input wire logic fetch_load,
   input wire logic [23:0] fetch_load_addr,
   output logic [23:0] fetch_addr,
   // Table request
   input wire psdm_pkg::psdm_tbl_req_t tbl_req,
   output logic [15:0] tbl_rdata,
   output logic tbl_rvalid,
   // Table write hand-off
   output logic prog_wt_valid,
   output logic prog_wt_high,
   output logic [23:0] prog_wt_addr,
   output logic [15:0] prog_wt_data,
   // Program memory port
   output logic [23:0] pmem_addr,
   output logic pmem_rd,
   input wire logic [23:0] pmem_rdata,
   // Instruction context
   input wire psdm_pkg::psdm_cls_t instr_class,
   input wire logic repeat_active,
   input wire logic repeat_first,
   input wire logic repeat_last,
   input wire logic repeat_irq_edge,
   // X path request
   input wire psdm_pkg::psdm_x_req_t x_req,
   input wire logic x_modulo,
   input wire logic [15:0] x_ram_rdata,
   output logic [15:0] x_rdata,
   output logic x_rvalid,
   output logic x_psv_hit,
   output logic [1:0] psv_penalty,
   // Y path request
   input wire logic y_req_valid,
   input wire logic [15:0] y_effective_address,
   input wire logic y_modulo,
   input wire logic [15:0] y_ram_rdata,
   output logic [15:0] y_rdata,
   output logic y_rvalid,
   // Data RAM port
   output logic [15:0] ram_x_addr,
   output logic ram_x_we,
   output logic [15:0] ram_x_wdata,
   output logic ram_x_bitrev,
   output logic ram_x_modulo,
   output logic [15:0] ram_y_addr,
   output logic ram_y_modulo
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic [23:0] pc;
      logic [15:0] tbl_rdata;
      logic tbl_rvalid;
      logic [15:0] x_rdata;
      logic x_rvalid;
      logic [15:0] y_rdata;
      logic y_rvalid;
      logic [1:0] penalty;
      logic psv_hit;
   } psdm_state_t;
   psdm_state_t st_reg;
   psdm_state_t st_next;
   logic dual_mac;
   logic tbl_busy;
   logic tbl_read;
   logic psv_sel;
   logic x_ok;
   logic y_ok;
   logic [23:0] tbl_addr;
   logic [23:0] psv_addr;
   logic [15:0] lane_data;
   logic [1:0] pen;
   assign dual_mac = instr_class == psdm_pkg::psdm_cls_dual_mac;
   assign tbl_busy = tbl_req.valid && tbl_req.op != psdm_pkg::psdm_tbl_none;
   assign tbl_read = tbl_req.valid && (tbl_req.op == psdm_pkg::psdm_tbl_rd_low
      || tbl_req.op == psdm_pkg::psdm_tbl_rd_high);
   // ----------------------------------------
   // Address formation
   // ----------------------------------------
   // Table address: page above EA, page top picks config space
   assign tbl_addr = {table_page_register, tbl_req.effective_address};
   // Visibility: bit 23 clear, page, low 15 EA bits
   assign psv_addr = {1'b0, visibility_page_register, x_req.effective_address[14:0]};
   // Visibility only on top-half EA, enable set, no table op
   assign psv_sel = x_req.valid && !x_req.is_write && x_req.effective_address[15]
      && program_space_visibility_enable && !tbl_busy;
   assign fetch_addr = {1'b0, st_reg.pc[22:1], 1'b0};
   // Program port arbitration: table, visibility, fetch
   always_comb
   begin
      pmem_rd = 1'b1;
      if (tbl_read)
         pmem_addr = tbl_addr;
      else if (psv_sel)
         pmem_addr = psv_addr;
      else
         pmem_addr = fetch_addr;
   end
   // ----------------------------------------
   // Sub-blocks
   // ----------------------------------------
   psdm_table_lane u_lane
   (
      .op(tbl_req.op),
      .byte_mode(tbl_req.byte_mode),
      .byte_sel(tbl_req.byte_sel),
      .pword(pmem_rdata),
      .data(lane_data)
   );
   psdm_space_decode u_xdec
   (
      .effective_address(x_req.effective_address),
      .dual_mac(dual_mac),
      .y_path(1'b0),
      .in_space(x_ok)
   );
   psdm_space_decode u_ydec
   (
      .effective_address(y_effective_address),
      .dual_mac(dual_mac),
      .y_path(1'b1),
      .in_space(y_ok)
   );
   // ----------------------------------------
   // Data RAM routing
   // ----------------------------------------
   // Writes only on X bus; bit reverse only for X writes
   assign ram_x_addr = x_req.effective_address;
   assign ram_x_we = x_req.valid && x_req.is_write && !x_req.effective_address[15];
   assign ram_x_wdata = x_req.wdata;
   assign ram_x_bitrev = x_req.valid && x_req.is_write && x_req.bit_reverse;
   assign ram_x_modulo = x_modulo;
   assign ram_y_addr = y_effective_address;
   assign ram_y_modulo = y_modulo && dual_mac;
   // Table writes handed to programming logic
   assign prog_wt_valid = tbl_req.valid && (tbl_req.op == psdm_pkg::psdm_tbl_wt_low
      || tbl_req.op == psdm_pkg::psdm_tbl_wt_high);
   assign prog_wt_high = tbl_req.op == psdm_pkg::psdm_tbl_wt_high;
   assign prog_wt_addr = tbl_addr;
   assign prog_wt_data = tbl_req.wdata;
   // ----------------------------------------
   // Visibility penalty
   // ----------------------------------------
   // Extra cycles by class and repeat position
   always_comb
   begin
      pen = psdm_pkg::PEN_ZERO;
      if (psv_sel)
      begin
         if (repeat_active)
         begin
            if (repeat_first || repeat_last || repeat_irq_edge)
               pen = psdm_pkg::PEN_TWO;
            else
               pen = psdm_pkg::PEN_ZERO;
         end
         else if (instr_class == psdm_pkg::psdm_cls_other)
            pen = psdm_pkg::PEN_TWO;
         else
            pen = psdm_pkg::PEN_ONE;
      end
   end
   // ----------------------------------------
   // Next state
   // ----------------------------------------
   // Fetch counter, registered read data
   always_comb
   begin
      st_next = st_reg;
      if (fetch_load)
         st_next.pc = fetch_load_addr;
      else if (fetch_advance)
         st_next.pc = st_reg.pc + psdm_pkg::PC_STEP;
      if (st_next.pc > psdm_pkg::USER_TOP)
         st_next.pc = psdm_pkg::PC_RESET;
      st_next.tbl_rvalid = tbl_read;
      st_next.tbl_rdata = tbl_read ? lane_data : 16'h0000;
      st_next.x_rvalid = x_req.valid && !x_req.is_write;
      if (psv_sel)
         st_next.x_rdata = pmem_rdata[15:0];
      else if (x_req.valid && !x_req.is_write && x_ok && !x_req.effective_address[15])
         st_next.x_rdata = x_ram_rdata;
      else
         st_next.x_rdata = 16'h0000;
      st_next.y_rvalid = y_req_valid;
      st_next.y_rdata = (y_req_valid && y_ok) ? y_ram_rdata : 16'h0000;
      st_next.penalty = pen;
      st_next.psv_hit = psv_sel;
   end
   // Register the state
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end
   assign tbl_rdata = st_reg.tbl_rdata;
   assign tbl_rvalid = st_reg.tbl_rvalid;
   assign x_rdata = st_reg.x_rdata;
   assign x_rvalid = st_reg.x_rvalid;
   assign y_rdata = st_reg.y_rdata;
   assign y_rvalid = st_reg.y_rvalid;
   assign psv_penalty = st_reg.penalty;
   assign x_psv_hit = st_reg.psv_hit;
   // ----------------------------------------
   // Checks
   // ----------------------------------------
   fetch_form_a: assert property (@(posedge clock) disable iff (!resetn)
      fetch_addr[23] == 1'b0 && fetch_addr[0] == 1'b0)
      else $error("fetch address malformed");
   pc_step_a: assert property (@(posedge clock) disable iff (!resetn)
      fetch_advance && !fetch_load && st_reg.pc < 24'h7ffffc
      |=> st_reg.pc == $past(st_reg.pc) + 24'h000002)
      else $error("program counter step wrong");
   psv_route_a: assert property (@(posedge clock) disable iff (!resetn)
      psv_sel |-> x_req.effective_address[15] && program_space_visibility_enable)
      else $error("visibility without enable");
   psv_addr_a: assert property (@(posedge clock) disable iff (!resetn)
      psv_sel && !tbl_read |-> pmem_addr == {1'b0, visibility_page_register,
      x_req.effective_address[14:0]})
      else $error("visibility address wrong");
   psv_data_a: assert property (@(posedge clock) disable iff (!resetn)
      psv_sel |=> x_rdata == $past(pmem_rdata[15:0]))
      else $error("visibility data wrong");
   psv_suspend_a: assert property (@(posedge clock) disable iff (!resetn)
      tbl_busy |=> !x_psv_hit)
      else $error("visibility during table op");
   high_read_a: assert property (@(posedge clock) disable iff (!resetn)
      tbl_read && tbl_req.op == psdm_pkg::psdm_tbl_rd_high |=> tbl_rdata[15:8] == 8'h00)
      else $error("high read upper byte not zero");
   pen_out_a: assert property (@(posedge clock) disable iff (!resetn)
      psv_sel && !repeat_active && instr_class == psdm_pkg::psdm_cls_move
      |=> psv_penalty == 2'h1)
      else $error("move penalty wrong");
   y_nowrite_a: assert property (@(posedge clock) disable iff (!resetn)
      x_req.valid && x_req.is_write && !x_req.effective_address[15]
      |-> ram_x_we && ram_x_addr == x_req.effective_address)
      else $error("write outside X bus");
   // Fetch counter wraps once past the user range
   pc_wrap_a: assert property (@(posedge clock) disable iff (!resetn)
      fetch_advance && !fetch_load && st_reg.pc == psdm_pkg::USER_TOP
      |=> st_reg.pc == psdm_pkg::PC_RESET)
      else $error("program counter left user range");
   // Table address is page over effective address
   tbl_addr_a: assert property (@(posedge clock) disable iff (!resetn)
      tbl_read |-> pmem_addr == {table_page_register, tbl_req.effective_address})
      else $error("table address wrong");
   // Config space only reachable from a table operation
   cfg_bit_a: assert property (@(posedge clock) disable iff (!resetn)
      !tbl_busy |-> pmem_addr[23] == 1'b0)
      else $error("bit 23 set outside table access");
   // Low word read returns the low program word
   low_read_a: assert property (@(posedge clock) disable iff (!resetn)
      tbl_read && tbl_req.op == psdm_pkg::psdm_tbl_rd_low && !tbl_req.byte_mode
      |=> tbl_rdata == $past(pmem_rdata[15:0]))
      else $error("low word read wrong");
   // Upper high byte always reads as zero
   byte_zero_a: assert property (@(posedge clock) disable iff (!resetn)
      tbl_read && tbl_req.op == psdm_pkg::psdm_tbl_rd_high && tbl_req.byte_mode
      && tbl_req.byte_sel |=> tbl_rdata == 16'h0000)
      else $error("high byte read not zero");
   // Two extra cycles for plain instructions
   other_pen_a: assert property (@(posedge clock) disable iff (!resetn)
      psv_sel && !repeat_active && instr_class == psdm_pkg::psdm_cls_other
      |=> psv_penalty == psdm_pkg::PEN_TWO)
      else $error("plain instruction penalty wrong");
   // Two extra cycles at loop edges
   rep_pen_a: assert property (@(posedge clock) disable iff (!resetn)
      psv_sel && repeat_active && (repeat_first || repeat_last || repeat_irq_edge)
      |=> psv_penalty == psdm_pkg::PEN_TWO)
      else $error("repeat edge penalty wrong");
   // Bit reverse only accompanies an X write
   bitrev_x_a: assert property (@(posedge clock) disable iff (!resetn)
      ram_x_bitrev |-> x_req.valid && x_req.is_write)
      else $error("bit reverse outside X write");
   // Reads past physical RAM come back zero
   x_stray_a: assert property (@(posedge clock) disable iff (!resetn)
      x_req.valid && !x_req.is_write && !psv_sel
      && x_req.effective_address > psdm_pkg::PHYS_END |=> x_rdata == 16'h0000)
      else $error("stray X read not zero");
   // Y path outside dual operand class reads zero
   y_stray_a: assert property (@(posedge clock) disable iff (!resetn)
      y_req_valid && !dual_mac |=> y_rdata == 16'h0000)
      else $error("stray Y read not zero");
   // Table writes handed on unchanged
   wt_pass_a: assert property (@(posedge clock) disable iff (!resetn)
      prog_wt_valid |-> prog_wt_addr == {table_page_register, tbl_req.effective_address}
      && prog_wt_data == tbl_req.wdata)
      else $error("table write hand-off wrong");
   // Main scenarios
   psv_cov: cover property (@(posedge clock) disable iff (!resetn) psv_sel);
   tbl_cov: cover property (@(posedge clock) disable iff (!resetn) tbl_read);
   mac_cov: cover property (@(posedge clock) disable iff (!resetn) dual_mac && y_req_valid);
   rep_cov: cover property (@(posedge clock) disable iff (!resetn) psv_sel && repeat_active);
   wt_cov: cover property (@(posedge clock) disable iff (!resetn) prog_wt_valid);
endmodule // psdm_mapper
`default_nettype wire

// [psdm_pkg.sv]
// Package of constants and carrier types for the program/data space mapper
// Functional notes
// - Fetch address: 24 bits, bits 23 and 0 zero
// - Program counter steps by two per word
// - Non-table accesses limited to user range
// - Table address is page over effective address
// - Bit 23 set only through table page
// - Low table read returns bits 15:0 or byte
// - High word read: bits 23:16, upper byte zero
// - High byte read: bits 23:16 or zero
// - Visibility needs address bit 15 and enable
// - Visibility address: zero, page, low 15 bits
// - Visibility returns low 16 program bits
// - Visibility suspended during table operations
// - Visibility penalty outside repeat: one or two
// - Visibility penalty inside repeat: two or zero
// - Dual operand: Y via y pointers, X via x pointers
// - Other instructions see one linear X space
// - All writes use X write bus only
// - Bit reverse on X writes only; modulo both
// - Outside assigned or physical space returns zero
// - X/Y boundary fixed, not software changeable
// - Unimplemented or wrong-pointer reads return zero
`default_nettype none
package psdm_pkg;
   // ----------------------------------------
   // Widths and boundaries
   // ----------------------------------------
   localparam int PA_W = 24;
   localparam int DA_W = 16;
   localparam logic [23:0] USER_TOP = 24'h7ffffe;
   localparam logic [23:0] PC_STEP = 24'h000002;
   localparam logic [23:0] PC_RESET = 24'h000000;
   localparam logic [15:0] Y_BASE = 16'h1800; // Fixed Y region start
   localparam logic [15:0] Y_END = 16'h27ff;  // Fixed Y region end
   localparam logic [15:0] PHYS_END = 16'h27ff; // Last implemented RAM byte
   localparam logic [15:0] PSV_BASE = 16'h8000;
   localparam logic [1:0] PEN_ZERO = 2'h0;
   localparam logic [1:0] PEN_ONE = 2'h1;
   localparam logic [1:0] PEN_TWO = 2'h2;
   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [2:0] {
      psdm_tbl_none, psdm_tbl_rd_low, psdm_tbl_rd_high, psdm_tbl_wt_low, psdm_tbl_wt_high
   } psdm_tbl_op_t;
   typedef enum logic [1:0] {
      psdm_cls_other, psdm_cls_move, psdm_cls_dual_mac
   } psdm_cls_t;
   typedef struct packed {
      logic valid;
      psdm_tbl_op_t op;
      logic byte_mode;
      logic byte_sel;
      logic [15:0] effective_address;
      logic [15:0] wdata;
   } psdm_tbl_req_t;
   typedef struct packed {
      logic valid;
      logic is_write;
      logic [15:0] effective_address;
      logic [15:0] wdata;
      logic bit_reverse;
   } psdm_x_req_t;
endpackage : psdm_pkg
`default_nettype wire

// [psdm_table_lane.sv]
// Table read lane selection from a program word
`timescale 1ns/1ps
`default_nettype none
module psdm_table_lane
(
   // Request shape
   input wire psdm_pkg::psdm_tbl_op_t op,
   input wire logic byte_mode,
   input wire logic byte_sel,
   // Program word and result
   input wire logic [23:0] pword,
   output logic [15:0] data
);
   // ----------------------------------------
   // Lane mapping
   // ----------------------------------------
   // Pick word or byte lane
   always_comb
   begin
      data = 16'h0000;
      if (op == psdm_pkg::psdm_tbl_rd_low)
      begin
         if (!byte_mode)
            data = pword[15:0];
         else
            data = byte_sel ? {8'h00, pword[15:8]} : {8'h00, pword[7:0]};
      end
      else if (op == psdm_pkg::psdm_tbl_rd_high)
      begin
         if (!byte_mode || !byte_sel)
            data = {8'h00, pword[23:16]};
         else
            data = 16'h0000;
      end
   end
endmodule // psdm_table_lane
`default_nettype wire

// [psdm_space_decode.sv]
// X/Y space decode with zero return for stray accesses
`timescale 1ns/1ps
`default_nettype none
module psdm_space_decode
(
   // Access shape
   input wire logic [15:0] effective_address,
   input wire logic dual_mac,
   input wire logic y_path,
   // Result
   output logic in_space
);
   logic in_y;
   logic phys;
   // ----------------------------------------
   // Region test
   // ----------------------------------------
   // Fixed boundary, no software control
   always_comb
   begin
      in_y = (effective_address >= psdm_pkg::Y_BASE) && (effective_address <= psdm_pkg::Y_END);
      phys = effective_address <= psdm_pkg::PHYS_END;
      if (!phys)
         in_space = 1'b0;
      else if (!dual_mac)
         in_space = !y_path;
      else if (y_path)
         in_space = in_y;
      else
         in_space = !in_y;
   end
endmodule // psdm_space_decode
`default_nettype wire

// [psdm_mem_model.sv]
// Memory model answering program and data RAM reads for the mapper
`timescale 1ns/1ps
`default_nettype none
module psdm_mem_model
(
   // Addresses from the mapper
   input wire logic [23:0] pmem_addr,
   input wire logic [15:0] ram_x_addr,
   input wire logic [15:0] ram_y_addr,
   // Same-cycle read data
   output logic [23:0] pmem_rdata,
   output logic [15:0] x_ram_rdata,
   output logic [15:0] y_ram_rdata
);
   // Distinct bytes per word, so a wrong lane or address shows
   function automatic logic [23:0] pw(input logic [23:0] a);
      return {a[7:0] ^ 8'ha5, a[15:0] ^ {a[23:16], 8'h3c}};
   endfunction
   // X and Y paths differ, so a crossed path shows
   function automatic logic [15:0] xd(input logic [15:0] a);
      return a ^ 16'h9e37;
   endfunction
   function automatic logic [15:0] yd(input logic [15:0] a);
      return {a[7:0], a[15:8]} ^ 16'h4b1d;
   endfunction
   // Combinational answers
   assign pmem_rdata = pw(pmem_addr);
   assign x_ram_rdata = xd(ram_x_addr);
   assign y_ram_rdata = yd(ram_y_addr);
endmodule // psdm_mem_model
`default_nettype wire

// [psdm_mapper_tb.sv]
// Self-checking bench for the program/data space mapper
`timescale 1ns/1ps
`default_nettype none
`define check_eq(g, e) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
$display("Error t=%0t got=%h exp=%h", $time, (g), (e)); end end
module psdm_mapper_tb;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] tpage = 8'h00, vpage = 8'h00;
   logic psv_en = 1'b0, adv = 1'b0, ld = 1'b0, mac, xin;
   logic [23:0] ld_addr = 24'h0, pc, e, fetch_addr, pmem_addr, pmem_rdata, wt_addr;
   psdm_pkg::psdm_tbl_req_t tbl = '0;
   psdm_pkg::psdm_x_req_t xr = '0;
   psdm_pkg::psdm_cls_t cls = psdm_pkg::psdm_cls_other;
   logic r_act = 1'b0, r_first = 1'b0, r_last = 1'b0, r_irq = 1'b0;
   logic xmod = 1'b0, ymod = 1'b0, yv = 1'b0, tbl_rvalid, wt_valid, wt_high, pmem_rd;
   logic x_rvalid, x_psv_hit, y_rvalid, ram_x_we, ram_x_bitrev, ram_x_modulo, ram_y_modulo;
   logic [15:0] yea = 16'h0, x_ram_rdata, y_ram_rdata, tbl_rdata, wt_data, x_rdata, y_rdata;
   logic [15:0] ram_x_addr, ram_x_wdata, ram_y_addr;
   logic [1:0] psv_penalty;
   int fail_count = 0, n_tests = 0, cycles = 0, n;
   // Clock
   always #2.5 clock = ~clock;
   psdm_mapper DUT (.clock(clock), .resetn(resetn), .table_page_register(tpage),
      .visibility_page_register(vpage), .program_space_visibility_enable(psv_en),
      .fetch_advance(adv), .fetch_load(ld), .fetch_load_addr(ld_addr),
      .fetch_addr(fetch_addr), .tbl_req(tbl), .tbl_rdata(tbl_rdata),
      .tbl_rvalid(tbl_rvalid), .prog_wt_valid(wt_valid), .prog_wt_high(wt_high),
      .prog_wt_addr(wt_addr), .prog_wt_data(wt_data), .pmem_addr(pmem_addr),
      .pmem_rd(pmem_rd), .pmem_rdata(pmem_rdata), .instr_class(cls),
      .repeat_active(r_act), .repeat_first(r_first), .repeat_last(r_last),
      .repeat_irq_edge(r_irq), .x_req(xr), .x_modulo(xmod), .x_ram_rdata(x_ram_rdata),
      .x_rdata(x_rdata), .x_rvalid(x_rvalid), .x_psv_hit(x_psv_hit),
      .psv_penalty(psv_penalty), .y_req_valid(yv), .y_effective_address(yea),
      .y_modulo(ymod), .y_ram_rdata(y_ram_rdata), .y_rdata(y_rdata), .y_rvalid(y_rvalid),
      .ram_x_addr(ram_x_addr), .ram_x_we(ram_x_we), .ram_x_wdata(ram_x_wdata),
      .ram_x_bitrev(ram_x_bitrev), .ram_x_modulo(ram_x_modulo), .ram_y_addr(ram_y_addr),
      .ram_y_modulo(ram_y_modulo));
   psdm_mem_model MEM (.pmem_addr(pmem_addr), .ram_x_addr(ram_x_addr),
      .ram_y_addr(ram_y_addr), .pmem_rdata(pmem_rdata), .x_ram_rdata(x_ram_rdata),
      .y_ram_rdata(y_ram_rdata));
   // Expected table read lane
   function automatic logic [15:0] lane(input logic hi, bm, bs, input logic [23:0] p);
      if (!hi)
         return bm ? {8'h00, bs ? p[15:8] : p[7:0]} : p[15:0];
      return {8'h00, (bm && bs) ? 8'h00 : p[23:16]};
   endfunction
   // Expected visibility penalty
   function automatic logic [1:0] pen(input logic oth, a, f, l, q);
      if (!a)
         return oth ? 2'h2 : 2'h1;
      return (f || l || q) ? 2'h2 : 2'h0;
   endfunction
   task automatic step;
      @(posedge clock);
      #1;
   endtask
   task automatic final_report;
      $display("Checks %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Hang guard
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 6000)
      begin
         fail_count++;
         final_report();
      end
   end
   // Main sequence
   initial
   begin
      void'($urandom(23));
      repeat (12) @(posedge clock);
      #1 resetn = 1'b1;
      `check_eq(fetch_addr, 24'h0)
      pc = 24'h0;
      adv = 1'b1;
      for (int i = 0; i < 10; i++)
      begin
         n = $urandom_range(1, 40);
         repeat (n) step();
         repeat (n) pc = (pc + 24'h2 > psdm_pkg::USER_TOP) ? 24'h0 : pc + 24'h2;
         `check_eq(fetch_addr, {1'b0, pc[22:1], 1'b0})
         ld_addr = (i == 9) ? 24'h7ffffe : 24'($urandom) >> i[0];
         ld = 1'b1;
         step();
         ld = 1'b0;
         pc = (ld_addr > psdm_pkg::USER_TOP) ? 24'h0 : ld_addr;
         `check_eq(fetch_addr, {1'b0, pc[22:1], 1'b0})
      end
      step();
      adv = 1'b0;
      `check_eq(fetch_addr, 24'h0)
      // Table reads beside a visibility read, then table writes
      for (int i = 0; i < 20; i++)
      begin
         tpage = 8'($urandom);
         psv_en = 1'b1;
         tbl = '{1'b1,
            (i >= 16) ? (i[0] ? psdm_pkg::psdm_tbl_wt_high : psdm_pkg::psdm_tbl_wt_low)
            : (i[0] ? psdm_pkg::psdm_tbl_rd_high : psdm_pkg::psdm_tbl_rd_low),
            i[1], i[2], {i[3], 15'($urandom)}, 16'($urandom)};
         xr = '{1'b1, 1'b0, 16'h8000 | 16'($urandom), 16'h0, 1'b0};
         e = {tpage, tbl.effective_address};
         #1;
         if (i >= 16)
         begin
            `check_eq({wt_valid, wt_high, wt_addr, wt_data}, {1'b1, i[0], e, tbl.wdata})
         end
         else
         begin
            `check_eq({pmem_addr, pmem_rd, wt_valid}, {e, 1'b1, 1'b0})
         end
         step();
         `check_eq(x_psv_hit, 1'b0)
         if (i < 16)
         begin
            `check_eq({tbl_rvalid, tbl_rdata}, {1'b1, lane(i[0], i[1], i[2], MEM.pw(e))})
         end
      end
      tbl.valid = 1'b0;
      // Visibility reads over classes and repeat states
      for (int i = 0; i < 48; i++)
      begin
         psv_en = (i < 42);
         vpage = 8'($urandom);
         cls = psdm_pkg::psdm_cls_t'(i % 3);
         {r_act, r_first, r_last, r_irq} = 4'($urandom);
         xr = '{1'b1, 1'b0, 16'h8000 | 16'($urandom), 16'h0, 1'b0};
         e = {1'b0, vpage, xr.effective_address[14:0]};
         #1;
         if (psv_en)
         begin
            `check_eq(pmem_addr, e)
         end
         step();
         `check_eq(x_psv_hit, psv_en)
         `check_eq(x_rdata, psv_en ? 16'(MEM.pw(e)) : 16'h0)
         if (psv_en)
         begin
            `check_eq(psv_penalty, pen(i % 3 == 0, r_act, r_first, r_last, r_irq))
         end
      end
      // Dual reads and writes across the X and Y regions
      psv_en = 1'b0;
      for (int i = 0; i < 96; i++)
      begin
         cls = psdm_pkg::psdm_cls_t'(i % 3);
         mac = (i % 3 == 2);
         {xmod, ymod} = 2'($urandom);
         xr = '{1'b1, i >= 64, (i >= 88) ? 16'h8000 | 16'($urandom)
            : 16'($urandom_range(0, 16'h2fff)), 16'($urandom), 1'($urandom)};
         yv = (i < 64);
         yea = 16'($urandom_range(0, 16'h2fff));
         #1;
         `check_eq(ram_x_we, xr.is_write && !xr.effective_address[15])
         `check_eq({ram_x_modulo, ram_y_modulo}, {xmod, ymod && mac})
         `check_eq(ram_y_addr, yea)
         if (ram_x_we === 1'b1)
         begin
            `check_eq({ram_x_addr, ram_x_wdata}, {xr.effective_address, xr.wdata})
         end
         if (!xr.effective_address[15])
         begin
            `check_eq(ram_x_bitrev, xr.is_write && xr.bit_reverse)
         end
         step();
         if (i < 64)
         begin
            xin = !(mac && xr.effective_address >= psdm_pkg::Y_BASE);
            xin = xin && xr.effective_address <= psdm_pkg::PHYS_END;
            `check_eq(x_rdata, xin ? MEM.xd(xr.effective_address) : 16'h0)
            xin = mac && yea >= psdm_pkg::Y_BASE && yea <= psdm_pkg::Y_END;
            `check_eq(y_rdata, xin ? MEM.yd(yea) : 16'h0)
            `check_eq({x_rvalid, y_rvalid}, 2'b11)
         end
      end
      final_report();
   end
endmodule // psdm_mapper_tb
`default_nettype wire
